// ===== hdl/serial_port_pkg.sv
package serial_port_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_RECEIVE_DATA = 3'h0;
  localparam logic [2:0] OFS_TRANSMIT_DATA = 3'h1;
  localparam logic [2:0] OFS_BAUD_DIVISOR_LOW = 3'h2;
  localparam logic [2:0] OFS_BAUD_DIVISOR_HIGH = 3'h3;
  localparam logic [2:0] OFS_TRANSMIT_STATUS = 3'h4;
  localparam logic [2:0] OFS_RECEIVE_STATUS = 3'h5;
  localparam logic [2:0] OFS_BAUD_CONTROL = 3'h6;
  localparam int POS_SYNC_MODE = 4;
  localparam int POS_HIGH_SPEED = 2;
  localparam int POS_TX_NINTH = 0;
  localparam int POS_RX_NINTH = 0;
  localparam int POS_WIDE_DIVISOR = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] FACTOR_64 = 7'h40;
  localparam logic [6:0] FACTOR_16 = 7'h10;
  localparam logic [6:0] FACTOR_4 = 7'h04;
endpackage

// ===== hdl/serial_port_data_and_baud_divider.sv
// Functional notes
// - Receive data register shows low eight received bits, read only.
// - Received character and its ninth bit are double buffered.
// - Transmit character low byte comes from the transmit data register.
// - Transmit data and ninth bit double buffered; write accepted while shifting.
// - Writing the divisor low byte restarts the baud counter.
// - Writing the divisor high byte restarts the baud counter.
// - Divisor is 16 bits: high register bits 15-8, low register 7-0.
// - High divisor byte ignored unless the wide divisor select is set.
// - Divisor n is the high and low registers concatenated.
// - Async, narrow, low speed: bit rate is clock over 64 times n+1.
// - Async, wide, low speed: bit rate is clock over 16 times n+1.
// - Sync mode: bit clock is clock over 4 times n+1.
// - Wide divisor select set picks 16 bits, clear picks 8 bits.
// - Sync mode select set means synchronous, clear asynchronous.
// - Ninth received bit reads in bit 0 of the receive status register.
//
// The placing of the registers and the strobed register port were chosen for this implementation.

////////////////////////////////////////////////////////////////////////////////

// Two-entry buffer; the head is a flip-flop so it can drive ports directly
module char_buffer2 #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] tail_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready <= (count_next != 2'h2);
      out_valid <= (count_next != 2'h0);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_data <= '0;
      tail_reg <= '0;
    end else begin
      if (pop && count_reg == 2'h2) begin
        out_data <= tail_reg;
      end
      if (push) begin
        if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
          out_data <= in_data;
        end else begin
          tail_reg <= in_data;
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module serial_port_data_and_baud_divider (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [serial_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_char_valid,
  input wire logic [8:0] rx_char_data,
  output logic rx_char_ready,
  output logic tx_char_valid,
  output logic [8:0] tx_char_data,
  input wire logic tx_char_ready,
  output logic sync_mode,
  output logic baud_tick
);
  logic [7:0] transmit_data_reg;
  logic [7:0] baud_divisor_low_reg;
  logic [7:0] baud_divisor_high_reg;
  logic high_speed_select_reg;
  logic transmit_ninth_bit_reg;
  logic wide_divisor_select_reg;
  logic rx_head_valid;
  logic [8:0] rx_head;
  logic rx_pop;
  logic tx_push;
  logic tx_room;
  logic [15:0] baud_divisor;
  logic [6:0] factor;
  logic [6:0] pre_cnt_reg;
  logic [15:0] div_cnt_reg;
  logic restart;
  logic tick_now;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  assign rx_pop = reg_rd && hit(reg_addr, serial_port_pkg::OFS_RECEIVE_DATA);
  assign tx_push = reg_wr && hit(reg_addr, serial_port_pkg::OFS_TRANSMIT_DATA);
  assign restart = reg_wr
    && (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_LOW)
    || hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_HIGH));

  // Receive side: the buffer holds the finished character while the next shifts
  char_buffer2 #(.WIDTH(9)) rx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(rx_char_valid),
    .in_data(rx_char_data),
    .in_ready(rx_char_ready),
    .out_valid(rx_head_valid),
    .out_data(rx_head),
    .out_ready(rx_pop)
  );

  // Transmit side: a write is dropped when both entries are occupied
  char_buffer2 #(.WIDTH(9)) tx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_push),
    .in_data({transmit_ninth_bit_reg, reg_wdata}),
    .in_ready(tx_room),
    .out_valid(tx_char_valid),
    .out_data(tx_char_data),
    .out_ready(tx_char_ready)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transmit_data_reg <= serial_port_pkg::RST_BYTE;
      baud_divisor_low_reg <= serial_port_pkg::RST_BYTE;
      baud_divisor_high_reg <= serial_port_pkg::RST_BYTE;
      sync_mode <= 1'b0;
      high_speed_select_reg <= 1'b0;
      transmit_ninth_bit_reg <= 1'b0;
      wide_divisor_select_reg <= 1'b0;
    end else if (reg_wr) begin
      if (hit(reg_addr, serial_port_pkg::OFS_TRANSMIT_DATA)) begin
        transmit_data_reg <= reg_wdata;
      end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_LOW)) begin
        baud_divisor_low_reg <= reg_wdata;
      end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_HIGH)) begin
        baud_divisor_high_reg <= reg_wdata;
      end else if (hit(reg_addr, serial_port_pkg::OFS_TRANSMIT_STATUS)) begin
        sync_mode <= reg_wdata[serial_port_pkg::POS_SYNC_MODE];
        high_speed_select_reg <= reg_wdata[serial_port_pkg::POS_HIGH_SPEED];
        transmit_ninth_bit_reg <= reg_wdata[serial_port_pkg::POS_TX_NINTH];
      end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_CONTROL)) begin
        wide_divisor_select_reg <=
          reg_wdata[serial_port_pkg::POS_WIDE_DIVISOR];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (hit(reg_addr, serial_port_pkg::OFS_RECEIVE_DATA)) begin
      reg_rdata <= rx_head[7:0];
    end else if (hit(reg_addr, serial_port_pkg::OFS_TRANSMIT_DATA)) begin
      reg_rdata <= transmit_data_reg;
    end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_LOW)) begin
      reg_rdata <= baud_divisor_low_reg;
    end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_HIGH)) begin
      reg_rdata <= baud_divisor_high_reg;
    end else if (hit(reg_addr, serial_port_pkg::OFS_TRANSMIT_STATUS)) begin
      reg_rdata <= 8'h00;
      reg_rdata[serial_port_pkg::POS_SYNC_MODE] <= sync_mode;
      reg_rdata[serial_port_pkg::POS_HIGH_SPEED] <= high_speed_select_reg;
      reg_rdata[serial_port_pkg::POS_TX_NINTH] <= transmit_ninth_bit_reg;
    end else if (hit(reg_addr, serial_port_pkg::OFS_RECEIVE_STATUS)) begin
      reg_rdata <= 8'h00;
      reg_rdata[serial_port_pkg::POS_RX_NINTH] <= rx_head[8];
    end else if (hit(reg_addr, serial_port_pkg::OFS_BAUD_CONTROL)) begin
      reg_rdata <= 8'h00;
      reg_rdata[serial_port_pkg::POS_WIDE_DIVISOR] <= wide_divisor_select_reg;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Narrow mode masks the high byte instead of clearing it, so it survives
  assign baud_divisor = wide_divisor_select_reg
    ? {baud_divisor_high_reg, baud_divisor_low_reg}
    : {8'h00, baud_divisor_low_reg};

  always_comb begin
    if (sync_mode) begin
      factor = serial_port_pkg::FACTOR_4;
    end else if (wide_divisor_select_reg) begin
      factor = high_speed_select_reg ? serial_port_pkg::FACTOR_4
        : serial_port_pkg::FACTOR_16;
    end else begin
      factor = high_speed_select_reg ? serial_port_pkg::FACTOR_16
        : serial_port_pkg::FACTOR_64;
    end
  end

  assign tick_now = (pre_cnt_reg >= factor - 7'h01)
    && (div_cnt_reg >= baud_divisor);

  // Compare with >= so a smaller divisor or factor never overruns the wrap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= 16'h0000;
      baud_tick <= 1'b0;
    end else if (restart) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= 16'h0000;
      baud_tick <= 1'b0;
    end else if (pre_cnt_reg >= factor - 7'h01) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= tick_now ? 16'h0000 : div_cnt_reg + 16'h0001;
      baud_tick <= tick_now;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
      baud_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [22:0] gap_cnt;
  logic [22:0] period;
  logic seen_tick;

  assign period = 23'(factor) * (23'(baud_divisor) + 23'h000001);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_cnt <= 23'h000000;
      seen_tick <= 1'b0;
    end else if (restart || reg_wr) begin
      gap_cnt <= 23'h000000;
      seen_tick <= 1'b0;
    end else if (baud_tick) begin
      gap_cnt <= 23'h000001;
      seen_tick <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 23'h000001;
    end
  end

  sequence s_rx_read;
    reg_rd && hit(reg_addr, serial_port_pkg::OFS_RECEIVE_DATA);
  endsequence

  property p_rx_data;
    @(posedge clk_sys) disable iff (rst)
    s_rx_read |=> reg_rdata == $past(rx_head[7:0]);
  endproperty
  a_rx_data: assert property (p_rx_data)
    else $error("receive data read wrong");

  property p_rx_ninth;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && hit(reg_addr, serial_port_pkg::OFS_RECEIVE_STATUS)
    |=> reg_rdata == {7'h00, $past(rx_head[8])};
  endproperty
  a_rx_ninth: assert property (p_rx_ninth)
    else $error("received ninth bit read wrong");

  property p_rx_hold;
    @(posedge clk_sys) disable iff (rst)
    rx_head_valid && !rx_pop |=> rx_head == $past(rx_head);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("buffered character changed before read");

  property p_tx_load;
    @(posedge clk_sys) disable iff (rst)
    tx_push && tx_room && !tx_char_valid
    |=> tx_char_valid
    && tx_char_data == $past({transmit_ninth_bit_reg, reg_wdata});
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit character not presented");

  sequence s_div_write;
    reg_wr && (hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_LOW)
      || hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_HIGH));
  endsequence

  property p_restart;
    @(posedge clk_sys) disable iff (rst)
    s_div_write |=> pre_cnt_reg == 7'h00 && div_cnt_reg == 16'h0000
    && !baud_tick;
  endproperty
  a_restart: assert property (p_restart)
    else $error("divisor write did not restart counter");

  property p_narrow;
    @(posedge clk_sys) disable iff (rst)
    // Spacing is rebuilt from the raw low byte, so a leaking high byte shows
    !wide_divisor_select_reg && baud_tick && seen_tick
    |-> gap_cnt == 23'(factor) * (23'(baud_divisor_low_reg) + 23'h000001);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("high divisor byte used in narrow mode");

  property p_concat;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && hit(reg_addr, serial_port_pkg::OFS_BAUD_DIVISOR_HIGH)
    && wide_divisor_select_reg
    |=> baud_divisor[15:8] == $past(reg_wdata);
  endproperty
  a_concat: assert property (p_concat)
    else $error("divisor high byte not in bits 15-8");

  property p_period;
    @(posedge clk_sys) disable iff (rst)
    baud_tick && seen_tick && !$past(reg_wr) |-> gap_cnt == period;
  endproperty
  a_period: assert property (p_period)
    else $error("baud tick spacing wrong");
endmodule

// ===== verif/serial_far_end.sv
module serial_far_end (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_char_ready,
  output logic rx_char_valid,
  output logic [8:0] rx_char_data,
  input wire logic tx_char_valid,
  input wire logic [8:0] tx_char_data,
  output logic tx_char_ready,
  input wire logic sink_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];
  logic [8:0] got_q[$];
  assign tx_char_ready = sink_ready;
  task automatic send(input logic [8:0] c);
    rx_q.push_back(c);
  endtask
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_char_valid <= 1'b0;
      rx_char_data <= 9'h000;
    end else begin
      if (rx_char_valid && rx_char_ready) begin
        void'(rx_q.pop_front());
      end
      if (tx_char_valid && tx_char_ready) begin
        got_q.push_back(tx_char_data);
      end
      // A refused char is held; idle data toggles so no stale value lingers
      if (rx_q.size() > 0) begin
        rx_char_valid <= 1'b1;
        rx_char_data <= rx_q[0];
      end else begin
        rx_char_valid <= 1'b0;
        rx_char_data <= ~rx_char_data;
      end
    end
  end
endmodule

// ===== verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [serial_port_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sink_ready = 1'b0;
  logic [7:0] reg_rdata;
  logic rx_char_valid, rx_char_ready, tx_char_valid, tx_char_ready;
  logic sync_mode, baud_tick;
  logic [8:0] rx_char_data, tx_char_data;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h51;
  logic [8:0] exp_q[$];
  serial_port_data_and_baud_divider uut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
    .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
    .sync_mode(sync_mode), .baud_tick(baud_tick));
  serial_far_end far (.clk_sys(clk_sys), .rst(rst),
    .rx_char_ready(rx_char_ready), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .tx_char_valid(tx_char_valid),
    .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
    .sink_ready(sink_ready));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard: sized well above the longest baud period sweep
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic meas(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (baud_tick !== 1'b1 && c < 20000);
  endtask
  initial begin
    logic [7:0] d, lo, hi;
    logic [8:0] c;
    logic sy, hs, wd;
    int f, k, got, occ;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1 `CHK("rx_ready", 1'b1, rx_char_ready)
    `CHK("tx_valid", 1'b0, tx_char_valid)
    wr(3'h0, 8'hFF);
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      `CHK("reset_read", 8'h00, d)
    end
    // Three chars offered: two fit, the third waits at the source
    for (int i = 0; i < 3; i++) begin
      c = 9'(rnd());
      exp_q.push_back(c);
      far.send(c);
    end
    repeat (6) @(posedge clk_sys);
    #1 `CHK("rx_full", 1'b0, rx_char_ready)
    for (int i = 0; i < 3; i++) begin
      rd(serial_port_pkg::OFS_RECEIVE_STATUS, d);
      `CHK("rx_ninth", exp_q[i][8], d[0])
      rd(serial_port_pkg::OFS_RECEIVE_DATA, d);
      `CHK("rx_data", exp_q[i][7:0], d)
    end
    exp_q.delete();
    occ = 0;
    for (int i = 0; i < 3; i++) begin
      c = 9'(rnd());
      wr(serial_port_pkg::OFS_TRANSMIT_STATUS, {7'h00, c[8]});
      wr(serial_port_pkg::OFS_TRANSMIT_DATA, c[7:0]);
      if (occ < 2) exp_q.push_back(c);
      occ++;
    end
    rd(serial_port_pkg::OFS_TRANSMIT_DATA, d);
    `CHK("tx_readback", c[7:0], d)
    `CHK("tx_head", exp_q[0], tx_char_data)
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      sink_ready <= 1'(rnd());
    end
    @(posedge clk_sys);
    sink_ready <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 `CHK("tx_count", exp_q.size(), far.got_q.size())
    for (int i = 0; i < exp_q.size() && i < far.got_q.size(); i++) begin
      `CHK("tx_char", exp_q[i], far.got_q[i])
    end
    for (int m = 0; m < 8; m++) begin
      {sy, hs, wd} = m[2:0];
      lo = {5'h00, 3'(rnd())};
      hi = wd ? 8'h01 : 8'h05;
      f = sy ? 4 : (wd ? (hs ? 4 : 16) : (hs ? 16 : 64));
      k = f * ((wd ? {hi, lo} : {8'h00, lo}) + 1);
      wr(serial_port_pkg::OFS_TRANSMIT_STATUS, {3'h0, sy, 1'b0, hs, 2'h0});
      wr(serial_port_pkg::OFS_BAUD_CONTROL, {4'h0, wd, 3'h0});
      wr(serial_port_pkg::OFS_BAUD_DIVISOR_HIGH, hi);
      wr(serial_port_pkg::OFS_BAUD_DIVISOR_LOW, lo);
      meas(got);
      `CHK("first_tick", k, got)
      meas(got);
      `CHK("period", k, got)
      wr(serial_port_pkg::OFS_BAUD_DIVISOR_HIGH, hi);
      meas(got);
      `CHK("restart_high", k, got)
      `CHK("sync_mode", sy, sync_mode)
      rd(serial_port_pkg::OFS_BAUD_DIVISOR_HIGH, d);
      `CHK("div_high", hi, d)
      rd(serial_port_pkg::OFS_BAUD_DIVISOR_LOW, d);
      `CHK("div_low", lo, d)
      rd(serial_port_pkg::OFS_TRANSMIT_STATUS, d);
      `CHK("tx_status", {3'h0, sy, 1'b0, hs, 2'h0}, d)
      rd(serial_port_pkg::OFS_BAUD_CONTROL, d);
      `CHK("baud_ctrl", {4'h0, wd, 3'h0}, d)
    end
    close_out();
  end
endmodule
